// >>> pkg/sos_pkg.sv
// constants and types shared by the status output signalling block
package sos_pkg;
    // apb register byte offsets
    localparam logic [7:0] SOS_CTRL_OFS = 8'h00;
    localparam logic [7:0] SOS_THRESH_OFS = 8'h04;
    localparam logic [7:0] SOS_FSCALE_OFS = 8'h08;
    localparam logic [7:0] SOS_ASCALE_OFS = 8'h0C;
    localparam logic [7:0] SOS_DSEL_OFS = 8'h10;
    localparam logic [7:0] SOS_STATUS_OFS = 8'h14;
    localparam logic [7:0] SOS_DISP_OFS = 8'h18;
    // control register field positions
    localparam int SOS_F1_LSB = 0;
    localparam int SOS_F2_LSB = 3;
    localparam int SOS_P1_BIT = 6;
    localparam int SOS_P2_BIT = 7;
    localparam int SOS_RPOL_BIT = 8;
    localparam int SOS_PID_BIT = 9;
    localparam int SOS_CLR_BIT = 16;
    // output function codes
    localparam logic [2:0] SOS_FUNC_DEV = 3'h4;
    localparam logic [2:0] SOS_FUNC_FAULT = 3'h5;
    // values after reset
    localparam logic [2:0] SOS_FUNC_RST = 3'h0;
    localparam logic SOS_OPOL_RST = 1'b0;
    localparam logic SOS_RPOL_RST = 1'b1;
    localparam logic [9:0] SOS_THRESH_RST = 10'h01E;
    localparam logic [13:0] SOS_FSCALE_RST = 14'h0064;
    localparam logic [13:0] SOS_ASCALE_RST = 14'h0064;
    localparam logic [3:0] SOS_DSEL_RST = 4'h1;
    // display selector codes
    localparam logic [3:0] SOS_D_FREQ = 4'h1;
    localparam logic [3:0] SOS_D_CURR = 4'h2;
    localparam logic [3:0] SOS_D_DIR = 4'h3;
    localparam logic [3:0] SOS_D_SACT = 4'h4;
    localparam logic [3:0] SOS_D_INS = 4'h5;
    localparam logic [3:0] SOS_D_OUTS = 4'h6;
    localparam logic [3:0] SOS_D_SFRQ = 4'h7;
    localparam logic [3:0] SOS_D_LAST = 4'h8;
    localparam logic [3:0] SOS_D_HIST = 4'h9;
    // timing
    localparam int SOS_CLK_HZ = 100_000_000;
    localparam int SOS_FAULT_DLY_MS = 300;
    localparam int SOS_PU_DLY_MS = 50;
    localparam int SOS_FAULT_DLY_CYC = SOS_FAULT_DLY_MS * (SOS_CLK_HZ / 1000);
    localparam int SOS_PU_DLY_CYC = SOS_PU_DLY_MS * (SOS_CLK_HZ / 1000);
    // display content kinds
    typedef enum logic [2:0] {
        SOS_DK_NUM = 3'b000,
        SOS_DK_NONE = 3'b001,
        SOS_DK_FWD = 3'b010,
        SOS_DK_REV = 3'b011,
        SOS_DK_STOP = 3'b100,
        SOS_DK_BITS = 3'b101
    } sos_dkind_t;
    // power-up sequencing
    typedef enum logic [0:0] {
        SOS_PU_WAIT = 1'b0,
        SOS_PU_RUN = 1'b1
    } sos_pu_t;
endpackage

// >>> rtl/sos_status_output.sv
// status outputs, fault relay, fault record and keypad display selection
// Behaviour
// - deviation alarm while pid active and exceeded
// - output function code 04 gives deviation alarm
// - output function code 05 gives fault alarm
// - fault alarm follows fault after 300 ms
// - output break contact closes only after powerup delay
// - relay code 01: make pair closed when healthy
// - relay code 00: make pair closes on fault
// - fault records kept across power removal
// - powerup resets state, relay not re-signalled
// - last fault item pages code, freq, current, voltage
// - history item shows second then third fault
// - frequency item shows frequency, hertz lamp lit
// - current item shows current, ampere lamp lit
// - direction item shows forward, reverse or stop
// - scaled actual item, only with pid active
// - input state item shows five inputs
// - output state item shows outputs and relay
// - scaled frequency item fits four digits
// - output polarity 01 turns make into break
`timescale 1ns/100ps
module sos_status_output
    import sos_pkg::*;
#(
    parameter int W = 16,
    parameter int FAULT_DLY_CYC = SOS_FAULT_DLY_CYC,
    parameter int PU_DLY_CYC = SOS_PU_DLY_CYC
)
(
    // clock, resets, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive values, same clock
    input wire logic [W-1:0] setpoint,
    input wire logic [W-1:0] actual,
    input wire logic [W-1:0] out_freq,
    input wire logic [W-1:0] motor_current,
    input wire logic [W-1:0] dc_bus_voltage,
    input wire logic [1:0] rotation,
    input wire logic fault_event,
    input wire logic [7:0] fault_code,
    // pins from outside
    input wire logic [4:0] dig_in,
    input wire logic program_key,
    // terminal outputs, high means contact closed
    output logic out_one_closed,
    output logic out_two_closed,
    output logic relay_make_terminal,
    output logic relay_break_terminal,
    // keypad display
    output logic [W-1:0] disp_value,
    output logic [1:0] disp_dp,
    output logic [2:0] disp_kind,
    output logic hz_lamp,
    output logic amp_lamp
);
    // registers
    logic [2:0] f1_r, f2_r;
    logic p1_r, p2_r, rpol_r, pid_r;
    logic [9:0] thresh_r;
    logic [13:0] fscale_r, ascale_r;
    logic [3:0] dsel_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    // fault and alarm state
    logic fault_r, alarm_r, dev_r;
    logic [31:0] fcnt_r, pucnt_r;
    sos_pu_t pu_r;
    logic clr_wr;
    // fault record, codes three deep, freq, current and voltage of the last fault only
    logic [7:0] hcode_r [0:2];
    logic [W-1:0] hfreq_r, hcurr_r, hdcv_r;
    logic [2:0] hval_r;
    // synchronisers
    logic [4:0] in_s1_r, in_s2_r;
    logic key_s1_r, key_s2_r, key_d_r;
    logic key_rise;
    // display
    logic [1:0] page_r;
    logic [W-1:0] disp_nxt;
    logic [1:0] dp_nxt;
    sos_dkind_t kind_nxt;
    logic [W-1:0] sfrq_v, sact_v;
    logic [1:0] sfrq_dp, sact_dp;
    logic [W:0] diff;
    logic wr, rd;

    // contact level of a programmable output from its function and polarity
    function automatic logic out_level(input logic [2:0] fsel, input logic pol,
                                       input logic dev, input logic alm, input logic pu);
        logic act;
        act = 1'b0;
        if (fsel == SOS_FUNC_DEV)
            act = dev;
        else if (fsel == SOS_FUNC_FAULT)
            act = alm;
        // break contact only closes once power-up settles
        out_level = pol ? (!act && pu) : act;
    endfunction

    // value in 0.01 units fitted to four digits; dp 3 means one trailing zero dropped
    function automatic logic [W+1:0] scale_fit(input logic [W-1:0] val, input logic [13:0] fac);
        logic [31:0] p;
        logic [31:0] v;
        p = 32'(val) * 32'(fac) / 32'd10;
        v = 32'h0;
        scale_fit = '0;
        if (p < 32'd10000)
        begin
            v = p;
            scale_fit[W+1:W] = 2'h2;
        end
        else if (p < 32'd100000)
        begin
            v = p / 32'd10;
            scale_fit[W+1:W] = 2'h1;
        end
        else if (p < 32'd1000000)
        begin
            v = p / 32'd100;
            scale_fit[W+1:W] = 2'h0;
        end
        else
        begin
            v = p / 32'd1000;
            scale_fit[W+1:W] = 2'h3;
        end
        if (v > 32'd9999)
            v = 32'd9999;
        scale_fit[W-1:0] = v[W-1:0];
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign clr_wr = wr && (paddr == SOS_CTRL_OFS) && pwdata[SOS_CLR_BIT];

    // register writes; unmapped writes are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            f1_r <= SOS_FUNC_RST;
            f2_r <= SOS_FUNC_RST;
            p1_r <= SOS_OPOL_RST;
            p2_r <= SOS_OPOL_RST;
            rpol_r <= SOS_RPOL_RST;
            pid_r <= 1'b0;
            thresh_r <= SOS_THRESH_RST;
            fscale_r <= SOS_FSCALE_RST;
            ascale_r <= SOS_ASCALE_RST;
            dsel_r <= SOS_DSEL_RST;
        end
        else if (ce && wr)
        begin
            if (paddr == SOS_CTRL_OFS)
            begin
                f1_r <= pwdata[SOS_F1_LSB +: 3];
                f2_r <= pwdata[SOS_F2_LSB +: 3];
                p1_r <= pwdata[SOS_P1_BIT];
                p2_r <= pwdata[SOS_P2_BIT];
                rpol_r <= pwdata[SOS_RPOL_BIT];
                pid_r <= pwdata[SOS_PID_BIT];
            end
            else if (paddr == SOS_THRESH_OFS)
                thresh_r <= (pwdata[9:0] > 10'd1000) ? 10'd1000 : pwdata[9:0];
            else if (paddr == SOS_FSCALE_OFS)
                fscale_r <= pwdata[13:0];
            else if (paddr == SOS_ASCALE_OFS)
                ascale_r <= pwdata[13:0];
            else if (paddr == SOS_DSEL_OFS)
                dsel_r <= pwdata[3:0];
        end
    end

    // read data captured in setup, held through access; error on unmapped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else if (ce && psel && !penable)
        begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
            if (paddr == SOS_CTRL_OFS)
                prdata_r <= {22'h0, pid_r, rpol_r, p2_r, p1_r, f2_r, f1_r};
            else if (paddr == SOS_THRESH_OFS)
                prdata_r <= {22'h0, thresh_r};
            else if (paddr == SOS_FSCALE_OFS)
                prdata_r <= {18'h0, fscale_r};
            else if (paddr == SOS_ASCALE_OFS)
                prdata_r <= {18'h0, ascale_r};
            else if (paddr == SOS_DSEL_OFS)
                prdata_r <= {28'h0, dsel_r};
            else if (paddr == SOS_STATUS_OFS)
                prdata_r <= {20'h0, hval_r, pu_r, relay_make_terminal, out_two_closed,
                             out_one_closed, dev_r, alarm_r, fault_r} & {32{rd}};
            else if (paddr == SOS_DISP_OFS)
                prdata_r <= {9'h0, disp_kind, page_r, disp_dp, disp_value};
            else
                pslverr_r <= 1'b1;
        end
    end

    // deviation magnitude in tenths of a percent
    assign diff = (setpoint > actual) ? ({1'b0, setpoint} - {1'b0, actual})
                                      : ({1'b0, actual} - {1'b0, setpoint});

    // deviation alarm follows the excess while pid runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dev_r <= 1'b0;
        else if (ce)
            dev_r <= pid_r && (diff > (W+1)'(thresh_r));
    end

    // fault latch; a new fault beats a clear in the same cycle, reset forgets it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_r <= 1'b0;
        else if (ce)
        begin
            if (fault_event)
                fault_r <= 1'b1;
            else if (clr_wr)
                fault_r <= 1'b0;
        end
    end

    // alarm rises a fixed time after the fault, drops with the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fcnt_r <= 32'h0;
            alarm_r <= 1'b0;
        end
        else if (ce)
        begin
            if (!fault_r)
            begin
                fcnt_r <= 32'h0;
                alarm_r <= 1'b0;
            end
            else if (fcnt_r < 32'(FAULT_DLY_CYC - 1))
                fcnt_r <= fcnt_r + 32'h1;
            else
                alarm_r <= 1'b1;
        end
    end

    // power-up delay after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pu_r <= SOS_PU_WAIT;
            pucnt_r <= 32'h0;
        end
        else if (ce)
        begin
            case (pu_r)
                SOS_PU_WAIT:
                begin
                    if (pucnt_r >= 32'(PU_DLY_CYC - 1))
                        pu_r <= SOS_PU_RUN;
                    else
                        pucnt_r <= pucnt_r + 32'h1;
                end
                default:
                    pu_r <= SOS_PU_RUN;
            endcase
        end
    end

    // terminal drive; combinational so the contacts track state at once
    assign out_one_closed = out_level(f1_r, p1_r, dev_r, alarm_r, pu_r == SOS_PU_RUN);
    assign out_two_closed = out_level(f2_r, p2_r, dev_r, alarm_r, pu_r == SOS_PU_RUN);
    always_comb
    begin
        if (rpol_r)
            relay_make_terminal = !alarm_r && (pu_r == SOS_PU_RUN);
        else
            relay_make_terminal = alarm_r;
        relay_break_terminal = !relay_make_terminal;
    end

    // fault records sit on the retention reset only, so device reset keeps them
    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
        begin
            hval_r <= 3'h0;
            hfreq_r <= '0;
            hcurr_r <= '0;
            hdcv_r <= '0;
            for (int i = 0; i < 3; i++)
                hcode_r[i] <= 8'h0;
        end
        else if (ce && fault_event)
        begin
            hcode_r[0] <= fault_code;
            hcode_r[1] <= hcode_r[0];
            hcode_r[2] <= hcode_r[1];
            hval_r <= {hval_r[1:0], 1'b1};
            hfreq_r <= out_freq;
            hcurr_r <= motor_current;
            hdcv_r <= dc_bus_voltage;
        end
    end

    // pins cross into the clock domain through two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_s1_r <= 5'h0;
            in_s2_r <= 5'h0;
            key_s1_r <= 1'b0;
            key_s2_r <= 1'b0;
            key_d_r <= 1'b0;
        end
        else if (ce)
        begin
            in_s1_r <= dig_in;
            in_s2_r <= in_s1_r;
            key_s1_r <= program_key;
            key_s2_r <= key_s1_r;
            key_d_r <= key_s2_r;
        end
    end
    assign key_rise = key_s2_r && !key_d_r;

    // page steps on each key press in the last fault and history items; a new selector write restarts at page 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            page_r <= 2'h0;
        else if (ce)
        begin
            if (wr && (paddr == SOS_DSEL_OFS))
                page_r <= 2'h0;
            else if (key_rise && dsel_r == SOS_D_LAST)
                page_r <= page_r + 2'h1;
            else if (key_rise && dsel_r == SOS_D_HIST)
                page_r <= {1'b0, !page_r[0]};
        end
    end

    assign {sfrq_dp, sfrq_v} = scale_fit(out_freq, fscale_r);
    assign {sact_dp, sact_v} = scale_fit(actual, ascale_r);

    // display content chosen by the selector
    always_comb
    begin
        disp_nxt = '0;
        dp_nxt = 2'h0;
        kind_nxt = SOS_DK_NUM;
        if (dsel_r == SOS_D_FREQ)
        begin
            disp_nxt = out_freq;
            dp_nxt = 2'h1;
        end
        else if (dsel_r == SOS_D_CURR)
        begin
            disp_nxt = motor_current;
            dp_nxt = 2'h2;
        end
        else if (dsel_r == SOS_D_DIR)
        begin
            if (out_freq == '0 || rotation == 2'h0)
                kind_nxt = SOS_DK_STOP;
            else if (rotation == 2'h1)
                kind_nxt = SOS_DK_FWD;
            else
                kind_nxt = SOS_DK_REV;
        end
        else if (dsel_r == SOS_D_SACT)
        begin
            if (pid_r)
            begin
                disp_nxt = sact_v;
                dp_nxt = sact_dp;
            end
            else
                kind_nxt = SOS_DK_NONE;
        end
        else if (dsel_r == SOS_D_INS)
        begin
            kind_nxt = SOS_DK_BITS;
            disp_nxt = W'(in_s2_r);
        end
        else if (dsel_r == SOS_D_OUTS)
        begin
            kind_nxt = SOS_DK_BITS;
            disp_nxt = W'({relay_make_terminal, out_two_closed, out_one_closed});
        end
        else if (dsel_r == SOS_D_SFRQ)
        begin
            disp_nxt = sfrq_v;
            dp_nxt = sfrq_dp;
        end
        else if (dsel_r == SOS_D_LAST)
        begin
            if (!hval_r[0])
                kind_nxt = SOS_DK_NONE;
            else if (page_r == 2'h0)
                disp_nxt = W'(hcode_r[0]);
            else if (page_r == 2'h1)
            begin
                disp_nxt = hfreq_r;
                dp_nxt = 2'h1;
            end
            else if (page_r == 2'h2)
            begin
                disp_nxt = hcurr_r;
                dp_nxt = 2'h2;
            end
            else
                disp_nxt = hdcv_r;
        end
        else if (dsel_r == SOS_D_HIST)
        begin
            if (!hval_r[1])
                kind_nxt = SOS_DK_NONE;
            else if (page_r[0] && !hval_r[2])
                kind_nxt = SOS_DK_NONE;
            else
                disp_nxt = W'(hcode_r[page_r[0] ? 2 : 1]);
        end
        else
            kind_nxt = SOS_DK_NONE;
    end

    // display outputs registered so the keypad sees steady values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            disp_value <= '0;
            disp_dp <= 2'h0;
            disp_kind <= SOS_DK_NONE;
            hz_lamp <= 1'b0;
            amp_lamp <= 1'b0;
        end
        else if (ce)
        begin
            disp_value <= disp_nxt;
            disp_dp <= dp_nxt;
            disp_kind <= kind_nxt;
            hz_lamp <= (dsel_r == SOS_D_FREQ);
            amp_lamp <= (dsel_r == SOS_D_CURR);
        end
    end
endmodule

// >>> sim/sos_plc_model.sv
// plc wiring and keypad operator beside the status outputs
`timescale 1ns/100ps
module sos_plc_model (
    // clock
    input wire logic pclk,
    // terminals read by the plc
    input wire logic out_one_closed,
    input wire logic out_two_closed,
    input wire logic relay_make_terminal,
    // operator commands
    input wire logic key_req,
    input wire logic [4:0] in_pat,
    // pins into the block
    output logic [4:0] dig_in,
    output logic program_key,
    // plc inputs, low while closed
    output logic [2:0] plc_in
);
    int hold = 0;
    initial
    begin
        dig_in = 5'h00;
        program_key = 1'b0;
    end
    // pull-ups: a closed contact reads low
    assign plc_in = ~{relay_make_terminal, out_two_closed, out_one_closed};
    // key held four cycles for the synchroniser
    always @(posedge pclk)
    begin
        dig_in <= in_pat;
        if (key_req)
            hold <= 8;
        else if (hold != 0)
            hold <= hold - 1;
        program_key <= (hold > 4);
    end
endmodule

// >>> sim/sos_status_output_chk.sv
// assertion checker for the status output signalling block
`timescale 1ns/100ps
module sos_status_output_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // fault and terminals
    input wire logic fault_event,
    input wire logic out_one_closed,
    input wire logic out_two_closed,
    input wire logic relay_make_terminal,
    input wire logic relay_break_terminal,
    // display
    input wire logic [2:0] disp_kind,
    input wire logic hz_lamp,
    input wire logic amp_lamp
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // changeover pairs opposite
    property p_relay_pair;
        relay_break_terminal == !relay_make_terminal;
    endproperty
    a_relay_pair: assert property (p_relay_pair)
        else $error("relay pairs agree");

    // outputs and relay make pair open in power-up delay
    property p_powerup;
        $rose(presetn) |-> (!relay_make_terminal && !out_one_closed && !out_two_closed)[*8];
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("early contact");

    // relay still early in delay
    property p_alarm_delay;
        fault_event && ce |=> ($stable(relay_make_terminal) || psel)[*8];
    endproperty
    a_alarm_delay: assert property (p_alarm_delay)
        else $error("early relay");

    // hertz lamp with a number
    property p_hz_lamp;
        hz_lamp |-> !amp_lamp && disp_kind == 3'd0;
    endproperty
    a_hz_lamp: assert property (p_hz_lamp)
        else $error("bad hertz lamp");

    // ampere lamp with a number
    property p_amp_lamp;
        amp_lamp |-> !hz_lamp && disp_kind == 3'd0;
    endproperty
    a_amp_lamp: assert property (p_amp_lamp)
        else $error("bad ampere lamp");

    // kind within codes
    property p_kind;
        disp_kind <= 3'd5;
    endproperty
    a_kind: assert property (p_kind)
        else $error("bad kind");

    // read data moves on setup only
    property p_rdata;
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data moved");

    // unmapped refused
    property p_slverr;
        psel && !penable && ce && paddr > 8'h18 |=> pslverr;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("no refusal");

    // mapped accepted
    property p_okay;
        psel && !penable && ce && paddr <= 8'h18 && paddr[1:0] == 2'b00 |=> !pslverr;
    endproperty
    a_okay: assert property (p_okay)
        else $error("false refusal");
endmodule

bind sos_status_output sos_status_output_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .paddr, .prdata,
    .pslverr, .fault_event, .out_one_closed, .out_two_closed, .relay_make_terminal, .relay_break_terminal,
    .disp_kind, .hz_lamp, .amp_lamp);

// >>> sim/sos_status_output_test.sv
// self-checking testbench for the status output signalling block
`timescale 1ns/100ps
module sos_status_output_test import sos_pkg::*;;
    localparam int FDLY = 20;
    localparam int PDLY = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fault_event = 1'b0, program_key, key_req = 1'b0;
    logic [15:0] setpoint = 16'h0, actual = 16'h0, out_freq = 16'h0, motor_current = 16'h0;
    logic [15:0] dc_bus_voltage = 16'h0, disp_value;
    logic [1:0] rotation = 2'h0, disp_dp;
    logic [7:0] fault_code = 8'h00;
    logic [4:0] dig_in, in_pat = 5'h00;
    logic out_one_closed, out_two_closed, relay_make_terminal, relay_break_terminal, hz_lamp, amp_lamp;
    logic [2:0] disp_kind, plc_in;
    logic [64:0] rdq[$];
    logic [64:0] note;
    int num_errors = 0, total_checks = 0;

    always #5 pclk = ~pclk;

    sos_status_output #(.W(16), .FAULT_DLY_CYC(FDLY), .PU_DLY_CYC(PDLY)) uut (.pclk, .presetn, .por_n, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .setpoint, .actual, .out_freq,
        .motor_current, .dc_bus_voltage, .rotation, .fault_event, .fault_code, .dig_in, .program_key,
        .out_one_closed, .out_two_closed, .relay_make_terminal, .relay_break_terminal, .disp_value, .disp_dp,
        .disp_kind, .hz_lamp, .amp_lamp);

    sos_plc_model u_plc (.pclk, .out_one_closed, .out_two_closed, .relay_make_terminal, .key_req, .in_pat,
        .dig_in, .program_key, .plc_in);

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task wt(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    // one apb transfer held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // a read queues refusal, mask and word
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic er);
        rdq.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask

    task pins(input logic [3:0] e);
        #1;
        chk({out_one_closed, out_two_closed, relay_make_terminal, relay_break_terminal}, e);
        chk(plc_in, 3'(~{e[1], e[2], e[3]}));
    endtask

    task fault(input logic [7:0] c);
        @(posedge pclk);
        fault_event <= 1'b1;
        fault_code <= c;
        @(posedge pclk);
        fault_event <= 1'b0;
    endtask

    task press;
        key_req <= 1'b1;
        @(posedge pclk);
        key_req <= 1'b0;
        wt(14);
    endtask

    task show(input logic [3:0] sel);
        apb(1'b1, SOS_DSEL_OFS, {28'h0, sel});
        wt(3);
    endtask

    // reads compared with the oldest note
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && rdq.size() > 0)
        begin
            note = rdq.pop_front();
            chk(prdata & note[63:32], note[31:0]);
            chk(pslverr, note[64]);
        end

    // watchdog well past the run
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        results();
    end

    initial
    begin
        int n, i, sp, ac;
        logic [7:0] c0;
        n = $urandom(32'hc033);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        pins(4'b0001);
        rd(SOS_CTRL_OFS, '1, 32'h100, 1'b0);
        rd(SOS_THRESH_OFS, 32'h3FF, 32'h1E, 1'b0);
        rd(SOS_FSCALE_OFS, 32'h3FFF, 32'h64, 1'b0);
        rd(SOS_ASCALE_OFS, 32'h3FFF, 32'h64, 1'b0);
        rd(8'h1C, '1, 32'h0, 1'b1);
        rd(SOS_STATUS_OFS, 32'h67, 32'h60, 1'b0);
        pins(4'b0010);
        // out1 fault alarm as break contact, out2 deviation alarm, pid on
        apb(1'b1, SOS_CTRL_OFS, 32'h365);
        repeat (2) @(posedge pclk);
        pins(4'b1010);
        // threshold edge both ways, then random
        for (i = 0; i < 10; i++)
        begin
            sp = (i < 2) ? 500 : $urandom_range(970, 30);
            ac = (i == 0) ? 470 : (i == 1) ? 531 : sp + int'($urandom_range(70)) - 35;
            @(posedge pclk);
            setpoint <= sp[15:0];
            actual <= ac[15:0];
            wt(3);
            chk(out_two_closed, ((sp > ac ? sp - ac : ac - sp) > 30));
        end
        apb(1'b1, SOS_CTRL_OFS, 32'h165);
        setpoint <= 16'd900;
        wt(3);
        chk(out_two_closed, 1'b0);
        // fault: late alarm opens out1 and relay
        @(posedge pclk);
        out_freq <= 16'd600;
        motor_current <= 16'd1234;
        dc_bus_voltage <= 16'd540;
        c0 = $urandom;
        fault(c0);
        repeat (FDLY / 2) @(posedge pclk);
        pins(4'b1010);
        repeat (FDLY) @(posedge pclk);
        pins(4'b0001);
        rd(SOS_STATUS_OFS, 32'h3, 32'h3, 1'b0);
        out_freq <= 16'd10;
        show(SOS_D_LAST);
        chk(disp_value, {8'h00, c0});
        press();
        chk(disp_value, 16'd600);
        press();
        chk(disp_value, 16'd1234);
        press();
        chk(disp_value, 16'd540);
        // power cycle keeps the record, relay quiet
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (PDLY + 3) @(posedge pclk);
        pins(4'b0010);
        show(SOS_D_LAST);
        chk(disp_value, {8'h00, c0});
        fault(8'h5A);
        show(SOS_D_HIST);
        chk(disp_value, {8'h00, c0});
        press();
        chk(disp_kind, SOS_DK_NONE);
        // relay polarity 00: make pair closes on fault
        apb(1'b1, SOS_CTRL_OFS, 32'h10000);
        repeat (3) @(posedge pclk);
        pins(4'b0001);
        fault(8'h33);
        repeat (FDLY / 2) @(posedge pclk);
        pins(4'b0001);
        repeat (FDLY) @(posedge pclk);
        pins(4'b0010);
        // keypad display items
        show(SOS_D_FREQ);
        chk({hz_lamp, amp_lamp, disp_value}, {2'b10, out_freq});
        show(SOS_D_CURR);
        chk({hz_lamp, amp_lamp, disp_value}, {2'b01, motor_current});
        show(SOS_D_DIR);
        for (i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            rotation <= i[1:0];
            wt(3);
            chk(disp_kind, (i == 0) ? SOS_DK_STOP : (i == 1) ? SOS_DK_FWD : SOS_DK_REV);
        end
        show(SOS_D_INS);
        @(posedge pclk);
        in_pat <= 5'($urandom);
        wt(6);
        chk({disp_kind, disp_value[4:0]}, {SOS_DK_BITS, in_pat});
        show(SOS_D_OUTS);
        chk({disp_kind, disp_value[2:0]}, {SOS_DK_BITS, 3'b100});
        show(SOS_D_SFRQ);
        chk({disp_dp, disp_value}, {2'h2, 16'h0064});
        show(SOS_D_SACT);
        chk(disp_kind, SOS_DK_NONE);
        results();
    end
endmodule
